// >>> core/wwdt_pkg.sv
// constants, field layouts and carrier types of the windowed watchdog
package wwdt_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_PERIOD   = 4'h1;
  localparam logic [3:0] OFF_WARN     = 4'h2;
  localparam logic [3:0] OFF_MASK_CLR = 4'h4;
  localparam logic [3:0] OFF_MASK_SET = 4'h5;
  localparam logic [3:0] OFF_FLAGS    = 4'h6;
  localparam logic [3:0] OFF_STATUS   = 4'h7;
  localparam logic [3:0] OFF_SERVICE  = 4'h8;
  // field positions
  localparam int CTRL_LOCK_BIT   = 7;
  localparam int CTRL_WEN_BIT    = 2;
  localparam int CTRL_EN_BIT     = 1;
  localparam int IRQ_EW_BIT      = 0;
  localparam int IRQ_SYNC_BIT    = 1;
  localparam int STATUS_BUSY_BIT = 7;
  localparam int CLOSED_LSB      = 4;
  // values
  localparam logic [7:0]  SERVICE_KEY     = 8'hA5;
  localparam logic [3:0]  PERIOD_CODE_MAX = 4'hB;
  localparam logic [15:0] PERIOD_BASE     = 16'h0008;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;

  // configuration held in the non-volatile user row
  typedef struct packed {
    logic       lock;
    logic       wen;
    logic       en;
    logic [3:0] closed_sel;
    logic [3:0] open_sel;
    logic [3:0] warn_off;
  } wwdt_nvm_type;

  // one write waiting to be carried into the count domain
  typedef struct packed {
    logic       valid;
    logic       is_key;
    logic [7:0] data;
  } wwdt_slot_type;

  typedef enum logic [1:0] {
    WWDT_IDLE   = 2'b00,
    WWDT_CLOSED = 2'b01,
    WWDT_OPEN   = 2'b11
  } wwdt_state_type;
endpackage

// >>> core/wwdt_top.sv
// windowed watchdog timer with register port and count-clock tick input
`timescale 1ns/1ps
module wwdt_top #(
  parameter int CNT_W = 16
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire wwdt_pkg::wwdt_nvm_type nvm_cfg,
  input  wire logic                  count_clock,
  input  wire logic [3:0]            addr,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic [7:0]                 rd_data,
  output logic                       irq,
  output logic                       sys_reset,
  output logic                       bus_stall
);
  // the counter must reach the longest period of 16384 ticks
  if (CNT_W < 15) begin : g_cnt_w_check
    $error("CNT_W must hold 16384");
  end

  // the longest period is 8 << 11, clamp reserved codes to that
  function automatic logic [CNT_W-1:0] period_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > wwdt_pkg::PERIOD_CODE_MAX) ? wwdt_pkg::PERIOD_CODE_MAX : code;
    return CNT_W'(wwdt_pkg::PERIOD_BASE << c);
  endfunction

  // count clock arrives from outside: three flops, agree on second and third
  logic [2:0] cc_sync_r;
  logic       cc_level_r;
  logic       tick_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      cc_sync_r  <= 3'h0;
      cc_level_r <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      cc_sync_r <= {cc_sync_r[1:0], count_clock};
      tick_r    <= 1'b0;
      if (cc_sync_r[1] == cc_sync_r[2]) begin
        cc_level_r <= cc_sync_r[2];
        tick_r     <= cc_sync_r[2] & ~cc_level_r;
      end
    end
  end

  // host-visible copies: written values read back at once
  logic       en_h_r;
  logic       wen_h_r;
  logic       lock_h_r;
  logic [3:0] closed_sel_r;
  logic [3:0] open_sel_r;
  logic [3:0] warn_off_r;
  logic [1:0] mask_r;
  logic [1:0] flags_r;
  // count-domain effective control
  logic       run_en_r;
  logic       wen_r;
  logic       lock_r;

  logic wr_ctrl;
  logic wr_key;
  logic cfg_open;
  logic [7:0] ctrl_nxt;
  assign wr_ctrl  = wr_stb && (addr == wwdt_pkg::OFF_CTRL);
  assign wr_key   = wr_stb && (addr == wwdt_pkg::OFF_SERVICE);
  assign cfg_open = !en_h_r && !lock_h_r;

  always_comb begin
    ctrl_nxt = 8'h00;
    ctrl_nxt[wwdt_pkg::CTRL_EN_BIT]   = lock_h_r ? en_h_r : wr_data[wwdt_pkg::CTRL_EN_BIT];
    ctrl_nxt[wwdt_pkg::CTRL_WEN_BIT]  = (cfg_open || lock_h_r) ?
                                        wr_data[wwdt_pkg::CTRL_WEN_BIT] : wen_h_r;
    // lock is write-one only
    ctrl_nxt[wwdt_pkg::CTRL_LOCK_BIT] = lock_h_r | wr_data[wwdt_pkg::CTRL_LOCK_BIT];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      en_h_r       <= nvm_cfg.en;
      wen_h_r      <= nvm_cfg.wen;
      lock_h_r     <= nvm_cfg.lock;
      closed_sel_r <= nvm_cfg.closed_sel;
      open_sel_r   <= nvm_cfg.open_sel;
      warn_off_r   <= nvm_cfg.warn_off;
    end else begin
      if (wr_ctrl) begin
        en_h_r   <= ctrl_nxt[wwdt_pkg::CTRL_EN_BIT];
        wen_h_r  <= ctrl_nxt[wwdt_pkg::CTRL_WEN_BIT];
        lock_h_r <= ctrl_nxt[wwdt_pkg::CTRL_LOCK_BIT];
      end
      if (wr_stb && addr == wwdt_pkg::OFF_PERIOD && cfg_open) begin
        closed_sel_r <= wr_data[wwdt_pkg::CLOSED_LSB +: 4];
        open_sel_r   <= wr_data[3:0];
      end
      if (wr_stb && addr == wwdt_pkg::OFF_WARN && cfg_open) begin
        warn_off_r <= wr_data[3:0];
      end
    end
  end

  // interrupt enables, writable in every mode
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= wwdt_pkg::IRQ_RESET;
    end else if (wr_stb && addr == wwdt_pkg::OFF_MASK_SET) begin
      mask_r <= mask_r | wr_data[1:0];
    end else if (wr_stb && addr == wwdt_pkg::OFF_MASK_CLR) begin
      mask_r <= mask_r & ~wr_data[1:0];
    end
  end

  // two-slot queue towards the count domain, applied on count ticks
  wwdt_pkg::wwdt_slot_type slot0_r;
  wwdt_pkg::wwdt_slot_type slot1_r;
  wwdt_pkg::wwdt_slot_type new_slot;
  logic sync_wr;
  logic apply;

  // control and service writes are queued
  assign sync_wr  = wr_ctrl || wr_key;
  assign apply    = tick_r && slot0_r.valid;
  assign new_slot = '{valid: 1'b1, is_key: wr_key, data: wr_key ? wr_data : ctrl_nxt};

  always_ff @(posedge clk) begin
    if (reset) begin
      slot0_r <= '0;
      slot1_r <= '0;
    end else if (apply) begin
      // second access waits its turn, nothing lost
      slot0_r <= slot1_r.valid ? slot1_r : (sync_wr ? new_slot : '0);
      slot1_r <= (slot1_r.valid && sync_wr) ? new_slot : '0;
    end else if (sync_wr) begin
      if (!slot0_r.valid) begin
        slot0_r <= new_slot;
      end else if (!slot1_r.valid) begin
        slot1_r <= new_slot;
      end
    end
  end

  logic stall_r;
  // stall while a further access cannot be held
  always_ff @(posedge clk) begin
    if (reset) begin
      stall_r <= 1'b0;
    end else begin
      stall_r <= slot0_r.valid && (slot1_r.valid || (sync_wr && !apply));
    end
  end

  // timer core, advanced by count ticks
  wwdt_pkg::wwdt_state_type state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             running;
  logic             key_ok;
  logic             svc;
  logic             svc_bad;
  logic             expire;
  logic             warn_hit;
  logic             open_start;
  logic             sysrst_r;

  assign running = run_en_r || lock_r;
  assign svc     = apply && slot0_r.is_key;
  assign key_ok  = slot0_r.data == wwdt_pkg::SERVICE_KEY;
  assign svc_bad = svc && (!key_ok || (running && state_r == wwdt_pkg::WWDT_CLOSED));
  assign expire  = tick_r && state_r == wwdt_pkg::WWDT_OPEN &&
                   (cnt_r + 1'b1) == period_len(open_sel_r);
  assign open_start = tick_r && state_r == wwdt_pkg::WWDT_CLOSED &&
                      (cnt_r + 1'b1) == period_len(closed_sel_r);
  // a later warn than timeout cannot fire
  assign warn_hit = tick_r && state_r == wwdt_pkg::WWDT_OPEN && !wen_r && !expire &&
                    (cnt_r + 1'b1) == period_len(warn_off_r);

  always_ff @(posedge clk) begin
    if (reset) begin
      run_en_r <= nvm_cfg.en;
      wen_r    <= nvm_cfg.wen;
      lock_r   <= nvm_cfg.lock;
    end else if (apply && !slot0_r.is_key) begin
      // enable takes effect in count domain
      run_en_r <= slot0_r.data[wwdt_pkg::CTRL_EN_BIT];
      wen_r    <= slot0_r.data[wwdt_pkg::CTRL_WEN_BIT];
      lock_r   <= lock_r | slot0_r.data[wwdt_pkg::CTRL_LOCK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= wwdt_pkg::WWDT_IDLE;
      cnt_r   <= '0;
    end else if (!running) begin
      state_r <= wwdt_pkg::WWDT_IDLE;
      cnt_r   <= '0;
    end else if (state_r == wwdt_pkg::WWDT_IDLE || (svc && key_ok)) begin
      state_r <= wen_r ? wwdt_pkg::WWDT_CLOSED : wwdt_pkg::WWDT_OPEN;
      cnt_r   <= '0;
    end else if (open_start) begin
      state_r <= wwdt_pkg::WWDT_OPEN;
      cnt_r   <= '0;
    end else if (tick_r && !expire) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // system reset held until the chip reset comes back
  always_ff @(posedge clk) begin
    if (reset) begin
      sysrst_r <= 1'b0;
    end else if (svc_bad || (running && expire)) begin
      sysrst_r <= 1'b1;
    end
  end

  // pending flags: set wins over a same-cycle clear
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  always_comb begin
    flag_set = 2'h0;
    flag_set[wwdt_pkg::IRQ_EW_BIT]   = running && (warn_hit || (open_start && wen_r));
    flag_set[wwdt_pkg::IRQ_SYNC_BIT] = apply;
    flag_clr = (wr_stb && addr == wwdt_pkg::OFF_FLAGS) ? wr_data[1:0] : 2'h0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= wwdt_pkg::IRQ_RESET;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  logic irq_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & mask_r);
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  logic [7:0] rd_nxt;
  logic [7:0] rd_data_r;
  always_comb begin
    rd_nxt = 8'h00;
    unique case (addr)
      wwdt_pkg::OFF_CTRL: begin
        rd_nxt[wwdt_pkg::CTRL_LOCK_BIT] = lock_h_r;
        rd_nxt[wwdt_pkg::CTRL_WEN_BIT]  = wen_h_r;
        rd_nxt[wwdt_pkg::CTRL_EN_BIT]   = en_h_r;
      end
      wwdt_pkg::OFF_PERIOD: rd_nxt = {closed_sel_r, open_sel_r};
      wwdt_pkg::OFF_WARN:   rd_nxt = {4'h0, warn_off_r};
      wwdt_pkg::OFF_MASK_CLR,
      wwdt_pkg::OFF_MASK_SET: rd_nxt = {6'h00, mask_r};
      wwdt_pkg::OFF_FLAGS:  rd_nxt = {6'h00, flags_r};
      wwdt_pkg::OFF_STATUS: rd_nxt[wwdt_pkg::STATUS_BUSY_BIT] = slot0_r.valid;
      default:              rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= wwdt_pkg::RDATA_RESET;
    end else begin
      rd_data_r <= rd_stb ? rd_nxt : 8'h00;
    end
  end

  assign rd_data   = rd_data_r;
  assign irq       = irq_r;
  assign sys_reset = sysrst_r;
  assign bus_stall = stall_r;
endmodule

// >>> dv/wwdt_properties.sv
// port-level assertions for the windowed watchdog
`timescale 1ns/1ps
module wwdt_properties (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire wwdt_pkg::wwdt_nvm_type nvm_cfg,
  input wire logic                   count_clock,
  input wire logic [3:0]             addr,
  input wire logic [7:0]             wr_data,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [7:0]             rd_data,
  input wire logic                   irq,
  input wire logic                   sys_reset,
  input wire logic                   bus_stall
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_mask_off;
    wr_stb && addr == wwdt_pkg::OFF_MASK_CLR && wr_data == 8'h03
    ##1 !(wr_stb && addr == wwdt_pkg::OFF_MASK_SET);
  endsequence
  // a lost write under stall is legal, so only accepted bad keys count
  sequence s_bad_key;
    wr_stb && !bus_stall && addr == wwdt_pkg::OFF_SERVICE && wr_data != wwdt_pkg::SERVICE_KEY;
  endsequence
  a_mask_off_irq: assert property (s_mask_off |=> !irq)
    else $error("irq still high after mask clear");
  a_masked_no_irq: assert property ($past(rd_stb) && $past(addr) == wwdt_pkg::OFF_MASK_SET
    && rd_data[1:0] == 2'h0 |-> !irq) else $error("irq with empty mask");
  a_bad_key_rst: assert property (s_bad_key |-> ##[1:40] sys_reset)
    else $error("bad key without system reset");
  a_sysrst_hold: assert property (sys_reset |=> sys_reset)
    else $error("system reset dropped");
  a_stall_cause: assert property ($rose(bus_stall) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("stall without a write");
  a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(rd_stb) && ($past(addr) == 4'h3 || $past(addr) > 4'h8)
    |-> rd_data == 8'h00) else $error("unmapped read nonzero");
  a_key_rd_zero: assert property ($past(rd_stb) && $past(addr) == wwdt_pkg::OFF_SERVICE
    |-> rd_data == 8'h00) else $error("service register read nonzero");
endmodule
bind wwdt_top wwdt_properties u_props (
  .clk(clk), .reset(reset), .nvm_cfg(nvm_cfg), .count_clock(count_clock),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .irq(irq), .sys_reset(sys_reset), .bus_stall(bus_stall)
);

// >>> dv/wwdt_host.sv
// host model driving the plain register port
`timescale 1ns/1ps
module wwdt_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       bus_stall,
  output logic [3:0]      addr,
  output logic [7:0]      wr_data,
  output logic            wr_stb,
  output logic            rd_stb
);
  initial begin
    addr = 4'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    // control and service writes during a stall would be lost
    while (bus_stall === 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 64) tb_top.fail_out("stall stuck");
    end
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic burst(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk);
    addr <= a;
    wr_data <= d0;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_data <= d1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module tb_top;
  logic                   clk;
  logic                   reset;
  logic                   count_clock;
  wwdt_pkg::wwdt_nvm_type nvm_cfg;
  logic [3:0]             addr;
  logic [7:0]             wr_data;
  logic                   wr_stb;
  logic                   rd_stb;
  logic [7:0]             rd_data;
  logic                   irq;
  logic                   sys_reset;
  logic                   bus_stall;
  int                     err_total;
  int                     checks;
  wwdt_top uut (.clk(clk), .reset(reset), .nvm_cfg(nvm_cfg), .count_clock(count_clock),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .irq(irq), .sys_reset(sys_reset), .bus_stall(bus_stall));
  wwdt_host host (.clk(clk), .rd_data(rd_data), .bus_stall(bus_stall), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count clock of 8 system cycles, phase unrelated to clk
  initial begin
    count_clock = 1'b0;
    #3;
    forever #20 count_clock = ~count_clock;
  end
  task automatic complete_run();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail_out(input string m);
    err_total++;
    $display("FAIL %0t %s", $time, m);
    complete_run();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] ex, input string m);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, ex);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] mk, input logic [7:0] ex);
    logic [7:0] d;
    host.rd(a, d);
    chk(d & mk, ex, "read");
  endtask
  task automatic por(input wwdt_pkg::wwdt_nvm_type v);
    @(posedge clk);
    nvm_cfg <= v;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
  endtask
  // lands just after the count tick so writes see a quiet queue
  task automatic tk(input int n);
    repeat (n) @(posedge count_clock);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic s, input logic ex, input string m);
    chk({7'h00, s}, {7'h00, ex}, m);
  endtask
  task automatic rise(input logic w, input int lo, input int hi, input string m);
    logic s;
    for (int i = 1; i <= hi; i++) begin
      tk(1);
      s = w ? irq : sys_reset;
      if (s === 1'b1) begin
        chk({7'h00, i >= lo}, 8'h01, m);
        return;
      end
    end
    fail_out(m);
  endtask
  task automatic t_boot();
    por({3'h2, 4'h3, 4'h2, 4'h5});
    rc(4'h0, 8'hFF, 8'h04);
    rc(4'h1, 8'hFF, 8'h32);
    rc(4'h2, 8'hFF, 8'h05);
    rc(4'h5, 8'hFF, 8'h00);
    rc(4'h3, 8'hFF, 8'h00);
    rc(4'hF, 8'hFF, 8'h00);
    $display("boot done");
  endtask
  task automatic t_enable();
    por({3'h0, 4'h0, 4'h1, 4'h0});
    host.wr(4'h0, 8'h02);
    // busy is read first: the write is applied at the next count tick
    rc(4'h7, 8'h80, 8'h80);
    rc(4'h0, 8'hFF, 8'h02);
    host.wr(4'h1, 8'h0B);
    rc(4'h1, 8'hFF, 8'h01);
    tk(2);
    rc(4'h6, 8'h02, 8'h02);
    rise(1'b0, 12, 17, "period 16");
    por({3'h1, 4'h0, 4'h0, 4'h0});
    tk(3);
    host.wr(4'h0, 8'h00);
    tk(12);
    pins(sys_reset, 1'b0, "stop");
    @(posedge count_clock);
    repeat (3) @(posedge clk);
    host.burst(4'h0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    pins(bus_stall, 1'b1, "stall");
    tk(3);
    pins(bus_stall, 1'b0, "drain");
    $display("enable done");
  endtask
  task automatic t_normal();
    por({3'h1, 4'h0, 4'h2, 4'h1});
    host.wr(4'h5, 8'h01);
    rise(1'b1, 13, 17, "warn");
    rc(4'h6, 8'hFF, 8'h01);
    host.wr(4'h6, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    pins(irq, 1'b0, "flag clear");
    rise(1'b0, 11, 17, "timeout 32");
    por({3'h1, 4'h0, 4'h0, 4'h3});
    host.wr(4'h5, 8'h01);
    rise(1'b0, 6, 9, "timeout 8");
    rc(4'h6, 8'h01, 8'h00);
    $display("normal done");
  endtask
  task automatic t_service();
    por({3'h1, 4'h0, 4'h1, 4'h0});
    for (int i = 0; i < 3; i++) begin
      tk(10);
      host.wr(4'h8, 8'hA5);
      rc(4'h7, 8'h80, 8'h80);
      pins(sys_reset, 1'b0, "served");
    end
    tk(2);
    rc(4'h6, 8'h02, 8'h02);
    host.wr(4'h8, 8'h5A);
    rise(1'b0, 1, 3, "bad key");
    $display("service done");
  endtask
  task automatic t_window();
    por({3'h3, 4'h1, 4'h1, 4'hF});
    host.wr(4'h5, 8'h03);
    rise(1'b1, 13, 17, "open start");
    host.wr(4'h4, 8'h03);
    repeat (3) @(posedge clk);
    #1;
    pins(irq, 1'b0, "mask clear");
    rise(1'b0, 12, 17, "window sum");
    por({3'h3, 4'h1, 4'h1, 4'hF});
    tk(20);
    host.wr(4'h8, 8'hA5);
    tk(4);
    pins(sys_reset, 1'b0, "open service");
    host.wr(4'h8, 8'hA5);
    rise(1'b0, 1, 3, "closed service");
    $display("window done");
  endtask
  task automatic t_lock();
    por({3'h4, 4'h0, 4'h0, 4'h0});
    host.wr(4'h0, 8'h00);
    host.wr(4'h1, 8'hBB);
    rc(4'h1, 8'hFF, 8'h00);
    host.wr(4'h2, 8'h07);
    rc(4'h2, 8'hFF, 8'h00);
    host.wr(4'h5, 8'h01);
    rc(4'h5, 8'h01, 8'h01);
    host.wr(4'h4, 8'h01);
    rc(4'h5, 8'h01, 8'h00);
    host.wr(4'h0, 8'h84);
    rc(4'h0, 8'h84, 8'h84);
    rise(1'b0, 1, 20, "locked run");
    $display("lock done");
  endtask
  initial begin
    err_total = 0;
    checks = 0;
    reset = 1'b1;
    nvm_cfg = '0;
    t_boot();
    t_enable();
    t_normal();
    t_service();
    t_window();
    t_lock();
    complete_run();
  end
endmodule
